// ### rtl/sas_map.svh
// Alarm codes, operation and stop modes and timing constants of the alarm supervisor
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

`define SAS_CODE_NONE      8'h00
`define SAS_CODE_SERIAL    8'h05
`define SAS_CODE_PARAM     8'h0B
`define SAS_CODE_MOVE_OFF  8'h15
`define SAS_CODE_MOVE_ORG  8'h16
`define SAS_CODE_ORG_TMO   8'h17
`define SAS_CODE_WRITE_MV  8'h18
`define SAS_CODE_POS_DATA  8'h19
`define SAS_CODE_OVERSPD   8'h1F
`define SAS_CODE_DEVIATION 8'h20
`define SAS_CODE_SOFTLIM   8'h21
`define SAS_CODE_PRESS     8'h22
`define SAS_CODE_ENC_COMM  8'h23
`define SAS_CODE_BATT_ERR  8'h25
`define SAS_CODE_BATT_LOW  8'h26
`define SAS_CODE_OVERTRVL  8'h27
`define SAS_CODE_NVM       8'h33
`define SAS_CODE_DETECT    8'h34
`define SAS_CODE_STALL     8'h36
`define SAS_CODE_ABNORMAL  8'h3A
`define SAS_CODE_ESTOP     8'h3F

`define SAS_MODE_MANUAL    3'h1
`define SAS_MODE_ABS_ONLY  3'h5
`define SAS_STOP_DEFER_LO  2'h1
`define SAS_STOP_DEFER_HI  2'h3

`define SAS_CLK_HZ         10000000
`define SAS_STALL_MS       2000
`define SAS_STALL_CYC      ((`SAS_CLK_HZ / 1000) * `SAS_STALL_MS)
`define SAS_HOME_TMO_CYC   30000000

`endif

// ### rtl/sas_pkg.sv
// Types shared by the alarm supervisor
package sas_pkg;

   // One detected fault: code and whether servo stays energized
   typedef struct packed {
      logic       valid;
      logic       holdServo;
      logic [7:0] code;
   } sas_alarm_t;

   typedef struct packed {
      logic signed [31:0] commandPos;
      logic signed [31:0] actualPos;
      logic signed [31:0] softLimitLow;
      logic signed [31:0] softLimitHigh;
      logic        [31:0] deviationLimit;
   } sas_pos_t;

   typedef struct packed {
      logic [15:0] speed;
      logic [15:0] maxSpeed;
   } sas_speed_t;

   typedef enum logic [2:0] {
      SAS_HOME_IDLE = 3'b001,
      SAS_HOME_RUN  = 3'b010,
      SAS_HOME_DONE = 3'b100
   } sas_home_t;

endpackage : sas_pkg

// ### rtl/sas_sync.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module sas_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,      // System clock
   input  wire logic             rst,      // Async reset, high
   input  wire logic [WIDTH-1:0] asyncIn,  // Pin levels
   output logic      [WIDTH-1:0] syncOut   // Synchronised levels
);

   logic [WIDTH-1:0] stage1_q;

   initial
   begin
      if (WIDTH < 1)
      begin
         $error("sas_sync: WIDTH must be at least 1");
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stage1_q <= '0;
         syncOut  <= '0;
      end
      else
      begin
         stage1_q <= asyncIn;
         syncOut  <= stage1_q;
      end
   end

endmodule : sas_sync

// ### rtl/sas_timer.sv
// Restartable cycle timer that flags expiry while armed
`timescale 1ns/10ps
module sas_timer #(
   parameter int unsigned LIMIT = 20000000
) (
   input  wire logic clk,      // System clock
   input  wire logic rst,      // Async reset, high
   input  wire logic run,      // Count while high
   input  wire logic restart,  // Reload count to zero
   output logic      expired   // Set after LIMIT cycles with run high
);

   logic [31:0] count_q;

   initial
   begin
      if (LIMIT < 1)
      begin
         $error("sas_timer: LIMIT must be at least 1");
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count_q <= 32'h0000_0000;
         expired <= 1'b0;
      end
      else if (restart || !run)
      begin
         count_q <= 32'h0000_0000;
         expired <= 1'b0;
      end
      else if (count_q < LIMIT - 1)
      begin
         count_q <= count_q + 32'h0000_0001;
      end
      else
      begin
         expired <= 1'b1;
      end
   end

endmodule : sas_timer

// ### rtl/sas_supervisor.sv
// Servo alarm supervisor: fault detection, alarm code latch and servo release
//
// How it works
// [RQ1] Servo-holding alarms leave the servo energized.
// [RQ2] Servo-releasing alarms switch the servo off.
// [RQ3] Move command with servo off: code 21, servo off.
// [RQ4] Position move before homing, or move during homing: code 22, servo on.
// [RQ5] Homing unfinished by preset timeout: code 23, servo off.
// [RQ6] Write strobe during manual move in mode 1: code 24, servo on.
// [RQ7] Empty entry, mode 5 relative target, bad press sign: code 25.
// [RQ8] Speed above maximum: code 31, servo on.
// [RQ9] Deviation above limit: code 32, servo off.
// [RQ10] Deferred stop modes 1 to 3 delay deviation alarm to next move.
// [RQ11] Position beyond either soft limit: code 33, servo on.
// [RQ12] Pushed back to target while pressing: code 34, servo off.
// [RQ13] Encoder link failure: code 35, servo off.
// [RQ14] No encoder feedback in excitation detection: code 52, servo off.
// [RQ15] No motion 2 s after move accepted: code 54, servo off.
// [RQ16] Storage check corrupt at start-up: code 51, servo off.
// [RQ17] Thrust opposing velocity while accelerating or at constant speed: code 58, servo off.
// [RQ18] Emergency stop asserted: code 63, servo off.
// [RQ19] Overtravel detected: code 39, servo off.
// [RQ20] Host serial link error: code 5, servo on.
// [RQ21] Parameter out of range: code 11, servo off.
// [RQ22] Battery low: code 38 servo on; battery absent or dead: code 37 off.
// [RQ23] Latest alarm code held until clear; zero when no alarm.
`timescale 1ns/10ps
`include "sas_map.svh"
module sas_supervisor
   import sas_pkg::*;
#(
   parameter int unsigned STALL_CYC    = `SAS_STALL_CYC,
   parameter int unsigned HOME_TMO_CYC = `SAS_HOME_TMO_CYC
) (
   input  wire logic       clk,                 // 10 MHz system clock
   input  wire logic       rst,                 // Async reset, high
   input  wire logic       servoOnReq,          // Host asks for servo energize
   input  wire logic       moveCmd,             // Move command pulse
   input  wire logic       moveIsPosition,      // Move is a position move
   input  wire logic       homingStart,         // Homing sequence start pulse
   input  wire logic       homingDone,          // Homing finished pulse
   input  wire logic [2:0] operationMode,       // Selected operation mode
   input  wire logic       manualMoving,        // Manual movement running
   input  wire logic       programEntryEmpty,   // Selected program entry empty
   input  wire logic       targetRelative,      // Target uses relative coordinate
   input  wire logic       pressSignInvalid,    // Pressing range sign invalid
   input  wire logic       pressing,            // Pressing operation active
   input  wire logic       pushedBackToTarget,  // Load forced unit to target
   input  wire logic       motorMoving,         // Motor motion seen
   input  wire logic       targetReached,       // Move reached target
   input  wire logic       accelOrCruise,       // Accelerating or constant speed
   input  wire logic       thrustOpposesVel,    // Thrust against velocity
   input  wire logic [1:0] deferredStopMode,    // Stop mode select
   input  sas_pos_t        pos,                 // Position values
   input  sas_speed_t      spd,                 // Speed values
   input  wire logic       encoderCommFail,     // Encoder link failure
   input  wire logic       excitationDetect,    // Excitation detection running
   input  wire logic       encoderFeedback,     // Encoder feedback seen
   input  wire logic       nvmCheckDone,        // Start-up storage check done pulse
   input  wire logic       nvmCorrupt,          // Storage check result bad
   input  wire logic       hostLinkError,       // Host serial link error
   input  wire logic       paramOutOfRange,     // Parameter outside valid range
   input  wire logic       positionWriteStrobe, // Pin: position write strobe
   input  wire logic       emergencyStopInput,  // Pin: emergency stop
   input  wire logic       overtravelSensor,    // Pin: overtravel detected
   input  wire logic       batteryLow,          // Pin: backup battery low
   input  wire logic       batteryAbsent,       // Pin: battery absent or dead
   input  wire logic       alarmClear,          // Clear alarm pulse
   output logic [7:0]      alarmCode,           // Latched alarm code
   output logic            alarmActive,         // Alarm present
   output logic            servoEnergize        // Drive stage enable
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [4:0] pinSync;
   logic       strobeSync;
   logic       estopSync;
   logic       otSync;
   logic       battLowSync;
   logic       battDeadSync;
   logic       strobeDly_q;

   sas_sync #(.WIDTH(5)) u_sync (
      .clk     (clk),
      .rst     (rst),
      .asyncIn ({positionWriteStrobe, emergencyStopInput, overtravelSensor, batteryLow, batteryAbsent}),
      .syncOut (pinSync)
   );

   assign {strobeSync, estopSync, otSync, battLowSync, battDeadSync} = pinSync;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         strobeDly_q <= 1'b0;
      end
      else
      begin
         strobeDly_q <= strobeSync;
      end
   end

   // ****************************************************************
   // Homing state and timers
   // ****************************************************************
   sas_home_t homeState_q;
   logic      homeTimeout;
   logic      moveRunning_q;
   logic      stallTimeout;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         homeState_q <= SAS_HOME_IDLE;
      end
      else
      begin
         unique case (homeState_q)
            SAS_HOME_IDLE, SAS_HOME_DONE:
            begin
               if (homingStart)
               begin
                  homeState_q <= SAS_HOME_RUN;
               end
            end
            SAS_HOME_RUN:
            begin
               if (homingDone)
               begin
                  homeState_q <= SAS_HOME_DONE;
               end
               else if (homeTimeout || !servoEnergize)
               begin
                  homeState_q <= SAS_HOME_IDLE;
               end
            end
            default:
            begin
               homeState_q <= SAS_HOME_IDLE;
            end
         endcase
      end
   end

   sas_timer #(.LIMIT(HOME_TMO_CYC)) u_home_tmr (
      .clk     (clk),
      .rst     (rst),
      .run     (homeState_q == SAS_HOME_RUN),
      .restart (homingStart),
      .expired (homeTimeout)
   );

   // Accepted move runs until the target is reached or servo drops
   // A new command outranks the reached flag, which still shows the previous move
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         moveRunning_q <= 1'b0;
      end
      else if (!servoEnergize)
      begin
         moveRunning_q <= 1'b0;
      end
      else if (moveCmd)
      begin
         moveRunning_q <= 1'b1; // RQ15
      end
      else if (targetReached)
      begin
         moveRunning_q <= 1'b0;
      end
   end

   sas_timer #(.LIMIT(STALL_CYC)) u_stall_tmr (
      .clk     (clk),
      .rst     (rst),
      .run     (moveRunning_q && !targetReached),
      .restart (motorMoving || moveCmd),
      .expired (stallTimeout) // RQ15
   );

   // ****************************************************************
   // Deviation with deferred reporting
   // ****************************************************************
   logic        [31:0] deviation;
   logic               devExceeded;
   logic               devPending_q;
   logic               deferMode;
   logic signed [32:0] devDiff;

   assign devDiff     = 33'(pos.commandPos) - 33'(pos.actualPos);
   assign deviation   = devDiff[32] ? 32'(-devDiff) : devDiff[31:0];
   assign devExceeded = deviation > pos.deviationLimit;
   assign deferMode   = (deferredStopMode >= `SAS_STOP_DEFER_LO) && (deferredStopMode <= `SAS_STOP_DEFER_HI); // RQ10

   // Pending flag survives until a move command or an alarm clear releases it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         devPending_q <= 1'b0;
      end
      else if (deferMode && devExceeded)
      begin
         devPending_q <= 1'b1; // RQ10
      end
      else if (moveCmd || alarmClear)
      begin
         devPending_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Fault selection, highest priority first
   // ****************************************************************
   function automatic sas_alarm_t mkAlarm(input logic [7:0] code, input logic hold);
      sas_alarm_t a;
      a.valid     = 1'b1;
      a.holdServo = hold;
      a.code      = code;
      return a;
   endfunction : mkAlarm

   sas_alarm_t fault;

   // Servo-releasing faults rank before holding ones, so a release is never masked
   always_comb
   begin
      fault = '0;
      if (estopSync)
         fault = mkAlarm(`SAS_CODE_ESTOP, 1'b0); // RQ18
      else if (otSync)
         fault = mkAlarm(`SAS_CODE_OVERTRVL, 1'b0); // RQ19
      else if (nvmCheckDone && nvmCorrupt)
         fault = mkAlarm(`SAS_CODE_NVM, 1'b0); // RQ16
      else if (paramOutOfRange)
         fault = mkAlarm(`SAS_CODE_PARAM, 1'b0); // RQ21
      else if (encoderCommFail)
         fault = mkAlarm(`SAS_CODE_ENC_COMM, 1'b0); // RQ13
      else if (excitationDetect && !encoderFeedback)
         fault = mkAlarm(`SAS_CODE_DETECT, 1'b0); // RQ14
      else if (battDeadSync)
         fault = mkAlarm(`SAS_CODE_BATT_ERR, 1'b0); // RQ22
      else if (moveCmd && !servoEnergize)
         fault = mkAlarm(`SAS_CODE_MOVE_OFF, 1'b0); // RQ3
      else if (homeTimeout && homeState_q == SAS_HOME_RUN)
         fault = mkAlarm(`SAS_CODE_ORG_TMO, 1'b0); // RQ5
      else if ((devExceeded && !deferMode) || (devPending_q && moveCmd))
         fault = mkAlarm(`SAS_CODE_DEVIATION, 1'b0); // RQ9
      else if (pressing && pushedBackToTarget)
         fault = mkAlarm(`SAS_CODE_PRESS, 1'b0); // RQ12
      else if (stallTimeout && moveRunning_q)
         fault = mkAlarm(`SAS_CODE_STALL, 1'b0); // RQ15
      else if (accelOrCruise && thrustOpposesVel)
         fault = mkAlarm(`SAS_CODE_ABNORMAL, 1'b0); // RQ17
      else if (moveCmd && ((moveIsPosition && homeState_q != SAS_HOME_DONE) || homeState_q == SAS_HOME_RUN))
         fault = mkAlarm(`SAS_CODE_MOVE_ORG, 1'b1); // RQ4
      else if (strobeSync && !strobeDly_q && manualMoving && operationMode == `SAS_MODE_MANUAL)
         fault = mkAlarm(`SAS_CODE_WRITE_MV, 1'b1); // RQ6
      else if (moveCmd && (programEntryEmpty || pressSignInvalid ||
                           (operationMode == `SAS_MODE_ABS_ONLY && targetRelative)))
         fault = mkAlarm(`SAS_CODE_POS_DATA, 1'b1); // RQ7
      else if (spd.speed > spd.maxSpeed)
         fault = mkAlarm(`SAS_CODE_OVERSPD, 1'b1); // RQ8
      else if ((pos.actualPos < pos.softLimitLow) || (pos.actualPos > pos.softLimitHigh))
         fault = mkAlarm(`SAS_CODE_SOFTLIM, 1'b1); // RQ11
      else if (battLowSync)
         fault = mkAlarm(`SAS_CODE_BATT_LOW, 1'b1); // RQ22
      else if (hostLinkError)
         fault = mkAlarm(`SAS_CODE_SERIAL, 1'b1); // RQ20
   end

   // ****************************************************************
   // Alarm latch and servo control
   // ****************************************************************
   // A fault in the clear cycle wins, so no event is lost
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         alarmCode   <= `SAS_CODE_NONE;
         alarmActive <= 1'b0;
      end
      else if (fault.valid)
      begin
         alarmCode   <= fault.code; // RQ23
         alarmActive <= 1'b1;
      end
      else if (alarmClear)
      begin
         alarmCode   <= `SAS_CODE_NONE; // RQ23
         alarmActive <= 1'b0;
      end
   end

   // After release the servo comes back while servoOnReq stays high, once alarmActive clears or on a holding fault
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         servoEnergize <= 1'b0;
      end
      else if (fault.valid && !fault.holdServo)
      begin
         servoEnergize <= 1'b0; // RQ2
      end
      else if (!servoOnReq)
      begin
         servoEnergize <= 1'b0;
      end
      else if (!alarmActive || (fault.valid && fault.holdServo) || servoEnergize)
      begin
         servoEnergize <= 1'b1; // RQ1
      end
   end

endmodule : sas_supervisor

// ### sim/sas_supervisor_chk.sv
// Port-level assertions of the servo alarm supervisor
`timescale 1ns/10ps
module sas_supervisor_chk (
   input logic       clk,                 // Clock
   input logic       rst,                 // Reset
   input logic       servoOnReq,          // Servo request
   input logic       moveCmd,             // Move pulse
   input logic       hostLinkError,       // Link error
   input logic       paramOutOfRange,     // Bad parameter
   input logic       nvmCheckDone,        // Check done
   input logic       nvmCorrupt,          // Check bad
   input logic       emergencyStopInput,  // Stop pin
   input logic       overtravelSensor,    // Travel pin
   input logic       alarmClear,          // Clear pulse
   input logic [7:0] alarmCode,           // Code out
   input logic       alarmActive,         // Alarm out
   input logic       servoEnergize        // Drive enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ****
   // Assertions
   // ****
   // Pins pass a two-stage synchroniser first
   AST_ESTOP: assert property (emergencyStopInput[*4] |=> !servoEnergize && alarmCode == 8'h3F)
      else $error("stop pin did not release servo");
   AST_OVERTRAVEL: assert property (overtravelSensor[*4] |=> !servoEnergize && alarmActive)
      else $error("overtravel did not release servo");
   AST_MOVE_OFF: assert property (moveCmd && !servoEnergize |=> alarmActive && !servoEnergize)
      else $error("move with servo off not flagged");
   AST_RELEASE: assert property (alarmActive && alarmCode inside {8'h0B, 8'h15, 8'h17, 8'h20, 8'h22,
      8'h23, 8'h25, 8'h27, 8'h33, 8'h34, 8'h36, 8'h3A, 8'h3F} |-> !servoEnergize)
      else $error("releasing alarm left servo on");
   AST_HOLD: assert property ($rose(alarmActive) && alarmCode inside {8'h05, 8'h16, 8'h18, 8'h19,
      8'h1F, 8'h21, 8'h26} && $past(servoEnergize) && $past(servoOnReq) |-> servoEnergize)
      else $error("holding alarm dropped servo");
   AST_NOCODE: assert property (!alarmActive |-> alarmCode == 8'h00)
      else $error("code shown without alarm");
   AST_LATCH: assert property (alarmActive && !alarmClear |=> alarmActive)
      else $error("alarm lost without clear");
   AST_SERIAL: assert property (hostLinkError |=> alarmActive)
      else $error("link error not flagged");
   AST_PARAM: assert property (paramOutOfRange |=> alarmActive && !servoEnergize)
      else $error("parameter error not flagged");
   AST_NVM: assert property (nvmCheckDone && nvmCorrupt |=> alarmActive && !servoEnergize)
      else $error("storage error not flagged");

   cover property ($rose(alarmActive) && servoEnergize);
   cover property (alarmCode == 8'h20);
   cover property (alarmCode == 8'h36);
endmodule : sas_supervisor_chk

bind sas_supervisor sas_supervisor_chk i_chk (.clk(clk), .rst(rst), .servoOnReq(servoOnReq),
   .moveCmd(moveCmd), .hostLinkError(hostLinkError), .paramOutOfRange(paramOutOfRange),
   .nvmCheckDone(nvmCheckDone), .nvmCorrupt(nvmCorrupt), .emergencyStopInput(emergencyStopInput),
   .overtravelSensor(overtravelSensor), .alarmClear(alarmClear), .alarmCode(alarmCode),
   .alarmActive(alarmActive), .servoEnergize(servoEnergize));

// ### sim/sas_plant.sv
// Drive stage and motor model answering move commands
`timescale 1ns/10ps
module sas_plant (
   input  wire logic       clk,            // Clock
   input  wire logic       rst,            // Reset
   input  wire logic       moveCmd,        // Move pulse
   input  wire logic       servoEnergize,  // Drive enable
   input  wire logic [1:0] manner,         // 0 prompt, 1 slow, 2 stuck
   output logic            motorMoving,    // Motion seen
   output logic            targetReached   // Move done
);
   logic [4:0] cnt_q;
   logic       run_q;
   logic [4:0] start;

   // Slow start stays under the stall time
   assign start = (manner == 2'h1) ? 5'h0A : 5'h00;
   assign motorMoving = run_q && manner != 2'h2 && cnt_q >= start && cnt_q < start + 5'h05;
   assign targetReached = run_q && manner != 2'h2 && cnt_q >= start + 5'h05;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         run_q <= 1'b0;
         cnt_q <= 5'h00;
      end
      else if (moveCmd && servoEnergize)
      begin
         run_q <= 1'b1;
         cnt_q <= 5'h00;
      end
      else if (run_q && cnt_q != 5'h1F)
         cnt_q <= cnt_q + 5'h01;
   end
endmodule : sas_plant

// ### sim/sas_supervisor_tb.sv
// Self-checking bench of the servo alarm supervisor
`timescale 1ns/10ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin failures++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module sas_supervisor_tb
   import sas_pkg::*;
;
   logic clk, rst, servoOnReq, moveCmd, moveIsPosition, homingStart, manualMoving, programEntryEmpty;
   logic pressing, pushedBackToTarget, accelOrCruise, thrustOpposesVel, encoderCommFail;
   logic excitationDetect, encoderFeedback, nvmCheckDone, nvmCorrupt, hostLinkError, paramOutOfRange;
   logic positionWriteStrobe, emergencyStopInput, overtravelSensor, batteryLow, batteryAbsent;
   logic alarmClear, alarmActive, servoEnergize, motorMoving, targetReached;
   logic [2:0] operationMode;
   logic [1:0] deferredStopMode, manner;
   logic [7:0] alarmCode;
   sas_pos_t   pos;
   sas_speed_t spd;
   int         failures, nCompared, cycles;
   logic [7:0] codes [17] = '{8'h18, 8'h1F, 8'h21, 8'h26, 8'h05, 8'h19, 8'h16, 8'h3F, 8'h27,
                             8'h33, 8'h0B, 8'h23, 8'h34, 8'h25, 8'h20, 8'h22, 8'h3A};

   // Short counts keep the run brief
   sas_supervisor #(.STALL_CYC(20), .HOME_TMO_CYC(30)) i_dut (.clk, .rst, .servoOnReq, .moveCmd,
      .moveIsPosition, .homingStart, .homingDone(1'b0), .operationMode, .manualMoving,
      .programEntryEmpty, .targetRelative(1'b0), .pressSignInvalid(1'b0), .pressing,
      .pushedBackToTarget, .motorMoving, .targetReached, .accelOrCruise, .thrustOpposesVel,
      .deferredStopMode, .pos, .spd, .encoderCommFail, .excitationDetect, .encoderFeedback,
      .nvmCheckDone, .nvmCorrupt, .hostLinkError, .paramOutOfRange, .positionWriteStrobe,
      .emergencyStopInput, .overtravelSensor, .batteryLow, .batteryAbsent, .alarmClear,
      .alarmCode, .alarmActive, .servoEnergize);

   sas_plant i_plant (.clk, .rst, .moveCmd, .servoEnergize, .manner, .motorMoving, .targetReached);

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ****
   // Helpers
   // ****
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic stop_test();
      if (failures == 0 && nCompared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   task automatic mv(logic p);
      moveIsPosition = p;
      moveCmd = 1'b1;
      cyc(1);
      moveCmd = 1'b0;
      moveIsPosition = 1'b0;
   endtask : mv

   task automatic servoOn();
      servoOnReq = 1'b0;
      cyc(1);
      servoOnReq = 1'b1;
      cyc(2);
   endtask : servoOn

   task automatic clr();
      alarmClear = 1'b1;
      cyc(1);
      alarmClear = 1'b0;
      cyc(1);
      `CHK(alarmCode, 8'h00)
      `CHK(alarmActive, 1'b0)
   endtask : clr

   task automatic drive(int i, logic v);
      case (i)
         0: begin operationMode = v ? 3'h1 : 3'h0; manualMoving = v; positionWriteStrobe = v; end
         1: spd.speed = v ? 16'h00C8 : 16'h0000;
         2: begin pos.commandPos = v ? 32'h0000_07D0 : '0; pos.actualPos = pos.commandPos; end
         3: batteryLow = v;
         4: hostLinkError = v;
         5: begin programEntryEmpty = v; if (v) mv(1'b0); end
         6: if (v) mv(1'b1);
         7: emergencyStopInput = v;
         8: overtravelSensor = v;
         9: begin nvmCorrupt = v; nvmCheckDone = v; if (v) begin cyc(1); nvmCheckDone = 1'b0; end end
         10: paramOutOfRange = v;
         11: encoderCommFail = v;
         12: begin excitationDetect = v; encoderFeedback = !v; end
         13: batteryAbsent = v;
         14: pos.actualPos = v ? 32'h0000_01F4 : '0;
         15: begin pressing = v; pushedBackToTarget = v; end
         default: begin accelOrCruise = v; thrustOpposesVel = v; end
      endcase
   endtask : drive

   // ****
   // Scenarios
   // ****
   task automatic tTable();
      for (int i = 0; i < 17; i++)
      begin
         servoOn();
         `CHK(servoEnergize, 1'b1)
         drive(i, 1'b1);
         cyc(6);
         `CHK(alarmCode, codes[i])
         `CHK(servoEnergize, logic'(i < 7))
         drive(i, 1'b0);
         cyc(4);
         clr();
      end
   endtask : tTable

   task automatic tMoveOff();
      servoOnReq = 1'b0;
      cyc(2);
      mv(1'b0);
      cyc(2);
      `CHK(alarmCode, 8'h15)
      `CHK(servoEnergize, 1'b0)
      clr();
   endtask : tMoveOff

   task automatic tHoming();
      int n;
      servoOn();
      homingStart = 1'b1;
      cyc(1);
      homingStart = 1'b0;
      mv(1'b0);
      cyc(2);
      `CHK(alarmCode, 8'h16)
      `CHK(servoEnergize, 1'b1)
      clr();
      n = 0;
      while (alarmActive !== 1'b1 && n < 60)
      begin
         cyc(1);
         n++;
      end
      `CHK(alarmCode, 8'h17)
      `CHK(servoEnergize, 1'b0)
      clr();
   endtask : tHoming

   task automatic tDefer();
      for (int m = 1; m < 4; m++)
      begin
         servoOn();
         deferredStopMode = 2'(m);
         pos.actualPos = 32'h0000_01F4;
         cyc(6);
         `CHK(alarmActive, 1'b0)
         pos.actualPos = '0;
         mv(1'b0);
         cyc(2);
         `CHK(alarmCode, 8'h20)
         `CHK(servoEnergize, 1'b0)
         deferredStopMode = 2'h0;
         clr();
      end
   endtask : tDefer

   task automatic tStall();
      int n;
      servoOn();
      manner = 2'h1;
      mv(1'b0);
      cyc(25);
      `CHK(alarmActive, 1'b0)
      manner = 2'h2;
      mv(1'b0);
      n = 0;
      while (alarmActive !== 1'b1 && n < 40)
      begin
         cyc(1);
         n++;
      end
      `CHK(alarmCode, 8'h36)
      `CHK(servoEnergize, 1'b0)
   endtask : tStall

   // ****
   // Main sequence and hang guard
   // ****
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         stop_test();
      end
   end

   initial
   begin
      {servoOnReq, moveCmd, moveIsPosition, homingStart, manualMoving, programEntryEmpty} = '0;
      {pressing, pushedBackToTarget, accelOrCruise, thrustOpposesVel, encoderCommFail} = '0;
      {excitationDetect, nvmCheckDone, nvmCorrupt, hostLinkError, paramOutOfRange} = '0;
      {positionWriteStrobe, emergencyStopInput, overtravelSensor, batteryLow, batteryAbsent} = '0;
      {alarmClear, operationMode, deferredStopMode, manner} = '0;
      encoderFeedback = 1'b1;
      pos = '0;
      pos.softLimitLow = -32'sd1000;
      pos.softLimitHigh = 32'sd1000;
      pos.deviationLimit = 32'h0000_0064;
      spd = '0;
      spd.maxSpeed = 16'h0064;
      failures = 0;
      nCompared = 0;
      cycles = 0;
      rst = 1'b1;
      cyc(4);
      rst = 1'b0;
      tTable();
      tMoveOff();
      tHoming();
      tDefer();
      tStall();
      stop_test();
   end
endmodule : sas_supervisor_tb
